/* timer2_pkg.sv */
// Purpose: constants for the wide timer and serial bit-rate logic
// Assumes: single 10 MHz clock, one oscillator period per clock
// Notes:   counts are in oscillator periods
package timer2_pkg;
	localparam int          CLK_HZ         = 10_000_000;
	localparam int          MACHINE_DIV    = 12;
	localparam int          STATE_DIV      = 2;
	localparam int          SER_DIV        = 16;
	localparam int          MODE2_DIV      = 32;
	localparam logic [15:0] COUNT_RESET    = 16'h0000;
	localparam logic [15:0] COUNT_MAX      = 16'hffff;
	localparam logic [7:0]  BYTE_MAX       = 8'hff;
	localparam logic [7:0]  BYTE_RESET     = 8'h00;
	localparam logic [3:0]  PRE_RESET      = 4'h0;
	localparam logic [1:0]  SER_MODE0      = 2'h0;
	localparam logic [1:0]  SER_MODE2      = 2'h2;
	localparam logic [3:0]  MACHINE_LAST   = 4'(MACHINE_DIV - 1);
	localparam logic [3:0]  STATE_LAST     = 4'(STATE_DIV - 1);
	localparam logic [3:0]  SER_LAST       = 4'(SER_DIV - 1);
	localparam logic [4:0]  MODE2_LAST     = 5'(MODE2_DIV - 1);
endpackage

/* timer2_serial_baud_generator.sv */
// Purpose: 16-bit wide timer with capture, auto-reload and bit-rate modes,
//          serial bit clock selection and double-buffered serial data path
// Assumes: pins synchronous to mclk; shift logic lives outside
// Notes:   control bits are plain ports
// Summary of operation
// - 16-bit timer/counter, timer or event counter, three modes.
// - capture without trigger: free 16-bit count, overflow sets overflow flag.
// - capture with trigger: falling trigger edge copies count, sets external flag.
// - auto-reload: overflow sets flag and reloads from reload/capture registers.
// - auto-reload with trigger: falling trigger edge also reloads, sets external flag.
// - bit-rate mode: high-byte rollover reloads the whole counter.
// - timer ticks every 12 clocks, every 2 clocks in bit-rate mode.
// - wide timer serial rate is its overflow rate over 16.
// - bit-rate mode holds only while a clock select bit is set.
// - bit-rate rollover sets no overflow flag and no interrupt.
// - bit-rate mode trigger edge sets external flag without reload.
// - receive and transmit clocks choose their timer independently.
// - serial mode 0 shifts at clock over 12.
// - serial mode 2 runs at clock over 64 while timer 1 does not overflow, or over 32 doubled.
// - timer 1 source: rate is 2^doubler over 32 of its overflows.
// - receiver is double-buffered; overrun loses one byte.
// - buffer write loads transmit register; read returns separate receive register.
// - counter function counts falling edges on the count pin.
// - receive select set uses wide timer, clear uses timer 1.
// - overflow flag set on wrap from ffff, cleared only by software.
module timer2_serial_baud_generator
	import timer2_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       arst_n,
	input  wire logic       wide_timer_run,
	input  wire logic       wide_timer_count_select,
	input  wire logic       capture_reload_select,
	input  wire logic       ext_trigger_enable,
	input  wire logic       rx_clock_select,
	input  wire logic       tx_clock_select,
	input  wire logic       baud_doubler,
	input  wire logic [1:0] serial_mode,
	input  wire logic       wide_timer_count_pin,
	input  wire logic       wide_timer_trigger_pin,
	input  wire logic       timer1_overflow,
	input  wire logic       flag_clear_overflow,
	input  wire logic       flag_clear_external,
	input  wire logic       reload_wr_low,
	input  wire logic       reload_wr_high,
	input  wire logic       count_wr_low,
	input  wire logic       count_wr_high,
	input  wire logic [7:0] wr_data,
	input  wire logic       serial_buffer_wr,
	input  wire logic       serial_buffer_rd,
	input  wire logic       rx_byte_done,
	input  wire logic [7:0] rx_shift_byte,
	output logic [15:0]     wide_count,
	output logic [15:0]     reload_capture,
	output logic            wide_timer_overflow_flag,
	output logic            wide_timer_external_flag,
	output logic            rx_bit_tick,
	output logic            tx_bit_tick,
	output logic            mode0_shift_tick,
	output logic [7:0]      tx_data,
	output logic            tx_load,
	output logic [7:0]      rx_data,
	output logic            rx_overrun
);
	// ----------------------------------------------------------------
	// state record
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] cnt;
		logic [15:0] rcap;
		logic        ovf;
		logic        exf;
		logic [3:0]  mpre;
		logic [3:0]  spre;
		logic        cpin;
		logic        tpin;
		logic [3:0]  rx16;
		logic [3:0]  tx16;
		logic        t1half;
		logic [4:0]  m2pre;
		logic        rxt;
		logic        txt;
		logic        m0t;
		logic [7:0]  txd;
		logic        txl;
		logic [7:0]  rxd;
		logic        rxfull;
		logic        ovr;
	} state_s;

	state_s st_r;
	state_s st_nxt;

	logic baud_mode;
	logic mach_tick;
	logic state_tick;
	logic trig_fall;
	logic cnt_fall;
	logic step;
	logic wrap;
	logic hi_roll;
	logic t2_ovf;
	logic t1_src;
	logic [15:0] inc;

	// one source choice, made alike for receive and transmit
	function automatic logic pick_src(input logic sel, input logic t2, input logic t1);
		return sel ? t2 : t1;
	endfunction

	// ----------------------------------------------------------------
	// timer core
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt     = st_r;
		baud_mode  = rx_clock_select | tx_clock_select;
		mach_tick  = (st_r.mpre == MACHINE_LAST);
		state_tick = (st_r.spre == STATE_LAST);
		st_nxt.mpre = mach_tick ? PRE_RESET : st_r.mpre + 4'h1;
		st_nxt.spre = state_tick ? PRE_RESET : st_r.spre + 4'h1;
		// pins sampled once per machine cycle, as edges need two samples
		if (mach_tick) begin
			st_nxt.cpin = wide_timer_count_pin;
			st_nxt.tpin = wide_timer_trigger_pin;
		end
		cnt_fall  = mach_tick & st_r.cpin & ~wide_timer_count_pin;
		trig_fall = mach_tick & st_r.tpin & ~wide_timer_trigger_pin;
		if (wide_timer_count_select)
			step = wide_timer_run & cnt_fall;
		else
			step = wide_timer_run & (baud_mode ? state_tick : mach_tick);
		inc     = st_r.cnt + 16'h0001;
		wrap    = step & (st_r.cnt == COUNT_MAX);
		hi_roll = wrap; // high byte rolls only on the full 16-bit wrap
		t2_ovf  = baud_mode & hi_roll;
		if (step)
			st_nxt.cnt = inc;
		// overflow flag left alone while generating bit rates
		if (baud_mode) begin
			if (hi_roll)
				st_nxt.cnt = st_r.rcap;
			// trigger only flags here, giving a spare interrupt source
			if (ext_trigger_enable & trig_fall)
				st_nxt.exf = 1'b1;
		end else if (capture_reload_select) begin
			if (wrap)
				st_nxt.ovf = 1'b1;
			if (ext_trigger_enable & trig_fall) begin
				st_nxt.rcap = step ? inc : st_r.cnt;
				st_nxt.exf  = 1'b1;
			end
		end else begin
			if (wrap) begin
				st_nxt.ovf = 1'b1;
				st_nxt.cnt = st_r.rcap;
			end
			if (ext_trigger_enable & trig_fall) begin
				st_nxt.cnt = st_r.rcap;
				st_nxt.exf = 1'b1;
			end
		end
		if (count_wr_low)
			st_nxt.cnt[7:0] = wr_data;
		if (count_wr_high)
			st_nxt.cnt[15:8] = wr_data;
		if (reload_wr_low)
			st_nxt.rcap[7:0] = wr_data;
		if (reload_wr_high)
			st_nxt.rcap[15:8] = wr_data;
		// set wins over a clear in the same cycle
		if (flag_clear_overflow & ~(wrap & ~baud_mode))
			st_nxt.ovf = 1'b0;
		if (flag_clear_external & ~(ext_trigger_enable & trig_fall))
			st_nxt.exf = 1'b0;

		// ------------------------------------------------------------
		// bit clock selection
		// ------------------------------------------------------------
		// timer 1 overflows halved unless doubled: 2^doubler/32 overall
		t1_src = 1'b0;
		if (timer1_overflow) begin
			st_nxt.t1half = ~st_r.t1half;
			t1_src        = baud_doubler | st_r.t1half;
		end
		st_nxt.rxt = 1'b0;
		st_nxt.txt = 1'b0;
		if (pick_src(rx_clock_select, t2_ovf, t1_src)) begin
			st_nxt.rx16 = st_r.rx16 + 4'h1;
			st_nxt.rxt  = (st_r.rx16 == SER_LAST);
		end
		if (pick_src(tx_clock_select, t2_ovf, t1_src)) begin
			st_nxt.tx16 = st_r.tx16 + 4'h1;
			st_nxt.txt  = (st_r.tx16 == SER_LAST);
		end
		st_nxt.m2pre = st_r.m2pre + 5'h01;
		if (serial_mode == SER_MODE2) begin
			st_nxt.rxt = (st_r.m2pre == MODE2_LAST) &
				(baud_doubler | st_nxt.t1half);
			st_nxt.txt = st_nxt.rxt;
		end
		// mode 2 borrows the timer 1 half bit; a same-cycle timer 1 overflow wins
		if ((serial_mode == SER_MODE2) & (st_r.m2pre == MODE2_LAST) & ~timer1_overflow)
			st_nxt.t1half = ~st_r.t1half;
		st_nxt.m0t = (serial_mode == SER_MODE0) & mach_tick;

		// ------------------------------------------------------------
		// serial data buffers
		// ------------------------------------------------------------
		st_nxt.txl = serial_buffer_wr;
		if (serial_buffer_wr)
			st_nxt.txd = wr_data;
		if (serial_buffer_rd)
			st_nxt.rxfull = 1'b0;
		if (rx_byte_done) begin
			// unread byte is overwritten: one byte lost, flagged
			st_nxt.rxd    = rx_shift_byte;
			st_nxt.rxfull = 1'b1;
			st_nxt.ovr    = st_r.rxfull & ~serial_buffer_rd;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign wide_count               = st_r.cnt;
	assign reload_capture           = st_r.rcap;
	assign wide_timer_overflow_flag = st_r.ovf;
	assign wide_timer_external_flag = st_r.exf;
	assign rx_bit_tick              = st_r.rxt;
	assign tx_bit_tick              = st_r.txt;
	assign mode0_shift_tick         = st_r.m0t;
	assign tx_data                  = st_r.txd;
	assign tx_load                  = st_r.txl;
	assign rx_data                  = st_r.rxd;
	assign rx_overrun               = st_r.ovr;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	ovf_on_wrap_a: assert property (wrap & ~baud_mode |=> st_r.ovf)
		else $error("overflow flag missed on wrap");
	reload_on_wrap_a: assert property (wrap & ~baud_mode & ~capture_reload_select
		& ~count_wr_low & ~count_wr_high |=> st_r.cnt == $past(st_r.rcap))
		else $error("auto-reload missed");
	capture_copy_a: assert property (~baud_mode & capture_reload_select & ext_trigger_enable
		& trig_fall & ~step & ~reload_wr_low & ~reload_wr_high
		|=> st_r.rcap == $past(st_r.cnt))
		else $error("capture missed");
	baud_no_ovf_a: assert property (baud_mode & ~st_r.ovf |=> ~st_r.ovf)
		else $error("overflow flag set in bit-rate mode");
	baud_reload_a: assert property (t2_ovf & ~count_wr_low & ~count_wr_high
		|=> st_r.cnt == $past(st_r.rcap))
		else $error("bit-rate reload missed");
	exf_set_a: assert property (ext_trigger_enable & trig_fall |=> st_r.exf)
		else $error("external flag missed");
	ovf_sticky_a: assert property (st_r.ovf & ~flag_clear_overflow |=> st_r.ovf)
		else $error("overflow flag dropped by hardware");
	mode0_rate_a: assert property (st_r.m0t |=> ~st_r.m0t [*8])
		else $error("mode 0 tick too frequent");
	tx_load_a: assert property (serial_buffer_wr |=> tx_load && tx_data == $past(wr_data))
		else $error("transmit load failed");
	overrun_a: assert property (rx_byte_done & st_r.rxfull & ~serial_buffer_rd
		|=> rx_overrun)
		else $error("overrun not flagged");
	count_step_a: assert property (step & (st_r.cnt != COUNT_MAX) & ~(ext_trigger_enable & trig_fall)
		& ~count_wr_low & ~count_wr_high
		|=> st_r.cnt == $past(st_r.cnt) + 16'h0001)
		else $error("count step missed");
	ext_no_reload_a: assert property (baud_mode & ext_trigger_enable & trig_fall & ~hi_roll
		& ~count_wr_low & ~count_wr_high
		|=> st_r.cnt == $past(st_r.cnt) + 16'($past(step)))
		else $error("trigger reloaded in bit-rate mode");
	trig_reload_a: assert property (~baud_mode & ~capture_reload_select & ext_trigger_enable
		& trig_fall & ~count_wr_low & ~count_wr_high |=> st_r.cnt == $past(st_r.rcap))
		else $error("trigger reload missed");
	ovf_clear_a: assert property (flag_clear_overflow & ~wrap |=> ~st_r.ovf)
		else $error("overflow flag not cleared");
	exf_sticky_a: assert property (st_r.exf & ~flag_clear_external |=> st_r.exf)
		else $error("external flag dropped by hardware");

	// ----------------------------------------------------------------
	// serial clock and transmit load checks
	// ----------------------------------------------------------------
	mode2_rate_a: assert property ($past(serial_mode == SER_MODE2) & (serial_mode == SER_MODE2)
		& st_r.rxt |=> ~st_r.rxt [*8])
		else $error("mode 2 tick too frequent");
	mode2_both_a: assert property (serial_mode == SER_MODE2 |=> st_r.txt == st_r.rxt)
		else $error("mode 2 ticks differ");
	rx_select_a: assert property (rx_clock_select & (serial_mode != SER_MODE2) & ~t2_ovf
		|=> ~st_r.rxt)
		else $error("receive tick from wrong source");
	tx_pulse_a: assert property (tx_load & ~serial_buffer_wr |=> ~tx_load)
		else $error("transmit load held too long");

	wrap_cov: cover property (wrap & ~baud_mode);
	capture_cov: cover property (capture_reload_select & ext_trigger_enable & trig_fall);
	baud_cov: cover property (st_r.rxt ##1 !st_r.rxt [*3] ##1 st_r.txt);
	overrun_cov: cover property (rx_byte_done & st_r.rxfull);
	count_cov: cover property (wide_timer_count_select & step);
endmodule

/* serial_shift_model.sv */
// Purpose: stand-in for the serial shift logic beyond the bit-rate block
// Assumes: one received byte per send request, answered three clocks later
// Notes:   data lines carry inverted junk outside the done pulse
module serial_shift_model (
	input  wire logic       mclk,
	input  wire logic       send,
	input  wire logic [7:0] send_byte,
	input  wire logic       tx_load,
	input  wire logic [7:0] tx_data,
	output logic            rx_byte_done,
	output logic [7:0]      rx_shift_byte,
	output logic [7:0]      last_tx
);
	timeunit 1ns;
	timeprecision 1ns;
	always @(posedge mclk) begin
		if (tx_load) last_tx <= tx_data;
	end
	// ----------------------------------------
	// receive side: byte whole, then released
	// ----------------------------------------
	initial begin
		rx_byte_done = 1'b0;
		rx_shift_byte = 8'h00;
		forever begin
			@(posedge send);
			repeat (3) @(negedge mclk);
			rx_shift_byte <= send_byte;
			rx_byte_done <= 1'b1;
			@(negedge mclk);
			rx_byte_done <= 1'b0;
			rx_shift_byte <= ~send_byte;
		end
	end
endmodule

/* tb.sv */
// Purpose: self-checking bench for the wide timer and bit-rate block
// Assumes: inputs change on the falling edge
// Notes:   trigger pin held 24 clocks per level, two pin samples each
module tb;
	import timer2_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk, arst_n, run, crs, exen, rxs, txs, dbl, tpin, t1en, t1ov, go, csel, cpin;
	logic [1:0]  t1c = 2'h0;
	logic        ovf, exf, rxt, txt, m0t, txl, ovr, rxd;
	logic [1:0]  smode;
	logic [7:0]  stb, wd, sb, rxb, last_tx, txd, rxdat;
	logic [15:0] cnt, rcap;
	int          n_mismatch = 0;
	int          cmp_count = 0;

	timer2_serial_baud_generator u_timer2_serial_baud_generator (
		.mclk, .arst_n, .wide_timer_run(run), .wide_timer_count_select(csel),
		.capture_reload_select(crs), .ext_trigger_enable(exen), .rx_clock_select(rxs),
		.tx_clock_select(txs), .baud_doubler(dbl), .serial_mode(smode),
		.wide_timer_count_pin(cpin), .wide_timer_trigger_pin(tpin), .timer1_overflow(t1ov),
		.flag_clear_overflow(stb[6]), .flag_clear_external(stb[7]),
		.reload_wr_low(stb[0]), .reload_wr_high(stb[1]), .count_wr_low(stb[2]),
		.count_wr_high(stb[3]), .wr_data(wd), .serial_buffer_wr(stb[4]),
		.serial_buffer_rd(stb[5]), .rx_byte_done(rxd), .rx_shift_byte(rxb),
		.wide_count(cnt), .reload_capture(rcap), .wide_timer_overflow_flag(ovf),
		.wide_timer_external_flag(exf), .rx_bit_tick(rxt), .tx_bit_tick(txt),
		.mode0_shift_tick(m0t), .tx_data(txd), .tx_load(txl), .rx_data(rxdat),
		.rx_overrun(ovr));
	serial_shift_model u_serial_shift_model (.mclk, .send(go), .send_byte(sb),
		.tx_load(txl), .tx_data(txd), .rx_byte_done(rxd), .rx_shift_byte(rxb), .last_tx);

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// timer 1 overflow every third clock; its interrupt is never modelled
	always @(negedge mclk) begin
		t1c <= (t1c == 2'h2) ? 2'h0 : t1c + 2'h1;
		t1ov <= t1en && t1c == 2'h0;
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic stop_test;
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	function automatic logic sig(input int s);
		case (s)
			0: return rxt;
			1: return txt;
			2: return m0t;
			default: return ovf;
		endcase
	endfunction
	task automatic wait_for(input int s, output int n);
		n = 0;
		while (sig(s) !== 1'b1 && n < 400) begin
			@(negedge mclk);
			n++;
		end
		if (n >= 400) begin
			n_mismatch++;
			stop_test();
		end
	endtask
	task automatic gap(input int s, input int e);
		int n;
		wait_for(s, n);
		@(negedge mclk);
		wait_for(s, n);
		chk("tick gap", 16'(e), 16'(n + 1));
	endtask
	task automatic pulse(input int k, input logic [7:0] d);
		@(negedge mclk);
		wd = d;
		stb[k] = 1'b1;
		@(negedge mclk);
		stb = '0;
	endtask
	task automatic set16(input int k, input logic [15:0] v);
		pulse(k, v[7:0]);
		pulse(k + 1, v[15:8]);
	endtask
	task automatic trig;
		repeat (24) @(negedge mclk);
		tpin = 1'b0;
		repeat (24) @(negedge mclk);
		tpin = 1'b1;
	endtask
	task automatic send(input logic [7:0] b);
		sb = b;
		go = 1'b1;
		repeat (6) @(negedge mclk);
		go = 1'b0;
		@(negedge mclk);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic s_wrap;
		int n;
		for (int m = 0; m < 2; m++) begin
			crs = m[0];
			set16(0, 16'h1234);
			set16(2, 16'hfffe);
			run = 1'b1;
			wait_for(3, n);
			chk("count after wrap", m ? 16'h0000 : 16'h1234, cnt);
			repeat (40) @(negedge mclk);
			chk("overflow held", 16'h1, 16'(ovf));
			run = 1'b0;
			pulse(6, 8'h00);
			chk("overflow cleared", 16'h0, 16'(ovf));
		end
	endtask
	task automatic s_trigger;
		logic [15:0] e;
		exen = 1'b1;
		for (int m = 0; m < 2; m++) begin
			crs = m[0];
			e = m ? 16'habcd : 16'h0055;
			set16(0, 16'h0055);
			set16(2, 16'habcd);
			trig();
			chk("ext flag", 16'h1, 16'(exf));
			chk("count", e, cnt);
			chk("reload", e, rcap);
			pulse(7, 8'h00);
			chk("ext cleared", 16'h0, 16'(exf));
		end
		crs = 1'b0;
	endtask
	task automatic s_baud;
		smode = 2'h1;
		set16(0, 16'hfffe);
		set16(2, 16'hfffe);
		{rxs, t1en, run} = 3'h7;
		gap(0, 64);
		gap(1, 96);
		dbl = 1'b1;
		gap(1, 48);
		chk("overflow", 16'h0, 16'(ovf));
		trig();
		chk("ext flag", 16'h1, 16'(exf));
		pulse(7, 8'h00);
		{rxs, t1en, run, dbl} = 4'h0;
	endtask
	task automatic s_modes;
		smode = SER_MODE0;
		gap(2, 12);
		smode = SER_MODE2;
		for (int d = 0; d < 2; d++) begin
			dbl = d[0];
			gap(0, 64 >> d);
		end
		dbl = 1'b0;
	endtask
	task automatic s_count;
		csel = 1'b1;
		set16(2, 16'h0010);
		run = 1'b1;
		repeat (3) begin
			repeat (24) @(negedge mclk);
			cpin = 1'b0;
			repeat (24) @(negedge mclk);
			cpin = 1'b1;
		end
		chk("event count", 16'h0013, cnt);
		{run, csel} = 2'h0;
	endtask
	task automatic s_serial;
		pulse(4, 8'h5a);
		@(negedge mclk);
		chk("tx data", 16'h005a, {8'h00, last_tx});
		send(8'h3c);
		chk("rx data", 16'h003c, {8'h00, rxdat});
		pulse(5, 8'h00);
		send(8'hc3);
		chk("overrun", 16'h0, 16'(ovr));
		send(8'h99);
		chk("overrun", 16'h1, 16'(ovr));
	endtask

	initial begin
		{run, crs, exen, rxs, txs, dbl, t1en, go, csel, stb, wd, sb, smode} = '0;
		tpin = 1'b1;
		cpin = 1'b1;
		arst_n = 1'b0;
		repeat (8) @(negedge mclk);
		arst_n = 1'b1;
		chk("count", 16'h0000, cnt);
		chk("flags", 16'h0000, {rcap[15:2], ovf, exf});
		s_wrap();
		s_trigger();
		s_baud();
		s_modes();
		s_count();
		s_serial();
		stop_test();
	end
endmodule
